// [common/pts_timer_regs.vh]
// Register offsets, field positions, reset values and timing counts for the period timer.
`ifndef PTS_TIMER_REGS_VH
`define PTS_TIMER_REGS_VH
`define PTS_OFF_COUNT      8'h00
`define PTS_OFF_PERIOD     8'h04
`define PTS_OFF_CONTROL    8'h08
`define PTS_OFF_HLT        8'h0C
`define PTS_OFF_RESET_SRC  8'h10
`define PTS_OFF_STATUS     8'h14
`define PTS_OFF_IRQ_EN     8'h18
`define PTS_CTL_POSTSCALE_SELECT_LO   0
`define PTS_CTL_POSTSCALE_SELECT_HI   3
`define PTS_CTL_CKPS_LO    4
`define PTS_CTL_CKPS_HI    6
`define PTS_CTL_ON         7
`define PTS_HLT_MODE_LO    0
`define PTS_HLT_MODE_HI    4
`define PTS_HLT_RUN_BIT_SYNC      5
`define PTS_HLT_PRESCALER_SYNC      6
`define PTS_COUNT_RST      8'h00
`define PTS_PERIOD_RST     8'hFF
`define PTS_SYNC_STAGES    2
`endif

// [src/pts_timer.v]
// Period timer with prescaler, postscaler, hardware limit modes and an AHB-Lite register slave.
`timescale 1ns/1ps
`include "pts_timer_regs.vh"

// What this block does
// - Eight-bit count and period registers, both readable and writable.
// - Input clock divided by prescaler 1:1 to 1:128 before counting.
// - Postscaler counts period matches, ratio 1:1 to 1:16.
// - Count increments on each prescaler output rising edge while running and not held by a gate.
// - Count equal period clears count next tick and bumps postscaler.
// - Postscaler match gives one instruction clock pulse and clears postscaler.
// - Reset clears count and loads period with 0xFF.
// - Scalers cleared on count write, control write, reset, external reset.
// - Control write leaves count unchanged.
// - Gate modes hold count while gate inactive, resume when active.
// - Reset modes clear count on configured level or edge.
// - One-shot clears run bit and stops on period match.
// - One-shot ignores non-zero postscale selection.
// - Monostable keeps run bit and restarts on external reset event.
// - Flag set on postscaler match; interrupt only when enabled; software clears.
// - Flag setting synchronised to instruction clock, up to two cycles late.
// - External reset source chosen by select field; starts, stops or resets.
// - Prescaler sync aligns prescaler output to instruction clock.
// - Run bit sync aligns run bit to timer input clock, losing one edge unless prescaler sync is on at 1:1.
// - Without run bit sync, run bit follows instruction clock immediately.
// - Period match goes out to PWM logic.
// - Selected external reset input forced low in debug mode.
// - Five-bit mode field: 00 free running, 01 one-shot, low bits select.
module pts_timer #(
    parameter NSRC = 4
) (
    input  wire            hclk,
    input  wire            hresetn,
    input  wire            hsel,
    input  wire [31:0]     haddr,
    input  wire [1:0]      htrans,
    input  wire            hwrite,
    input  wire [2:0]      hsize,
    input  wire [31:0]     hwdata,
    input  wire            hready,
    output reg  [31:0]     hrdata,
    output reg             hreadyout,
    output reg             hresp,
    input  wire            timer_input_clock,
    input  wire [NSRC-1:0] reset_sources,
    input  wire            debug_mode,
    output reg             postscaled_pulse,
    output reg             period_match,
    output reg             timer_irq
);
    // Register state.
    reg [7:0]  count_value_q;
    reg [7:0]  period_value_q;
    reg [7:0]  timer_control_register_q;
    reg [6:0]  hardware_limit_timer_q;
    reg [1:0]  reset_source_field_q;
    reg        irq_flag_q;
    reg        match_irq_enable_q;
    reg [7:0]  presc_q;
    reg [3:0]  post_q;
    reg        tclk_q;
    reg        ers_q;
    reg        run_q;
    reg        os_armed_q;
    reg        flag_sync1_q;
    reg        flag_sync2_q;
    reg        presc_out_q;
    reg        wr_pend_q;
    reg [7:0]  addr_q;

    wire       on_bit      = timer_control_register_q[`PTS_CTL_ON];
    wire [3:0] postscale_select       = timer_control_register_q[`PTS_CTL_POSTSCALE_SELECT_HI:`PTS_CTL_POSTSCALE_SELECT_LO];
    wire [2:0] ckps        = timer_control_register_q[`PTS_CTL_CKPS_HI:`PTS_CTL_CKPS_LO];
    wire [4:0] mode        = hardware_limit_timer_q[`PTS_HLT_MODE_HI:`PTS_HLT_MODE_LO];
    wire       run_bit_sync = hardware_limit_timer_q[`PTS_HLT_RUN_BIT_SYNC];
    wire       prescaler_sync = hardware_limit_timer_q[`PTS_HLT_PRESCALER_SYNC];

    // Prescaler ratio as a power of two; true when the prescaler wraps this tick.
    function presc_wrap;
        input [7:0] cnt;
        input [2:0] sel;
        reg   [7:0] lim;
        begin
            lim = (8'h01 << sel) - 8'h01;
            presc_wrap = (cnt == lim);
        end
    endfunction

    // The timer input clock is sampled as an ordinary synchronous input; its rising edge is a tick.
    wire tclk_rise = timer_input_clock & ~tclk_q;
    wire ers_raw   = reset_sources[reset_source_field_q] & ~debug_mode;
    wire ers_rise  = ers_raw & ~ers_q;
    wire ers_fall  = ~ers_raw & ers_q;
    wire ers_any   = ers_rise | ers_fall;

    // True when a pending write targets the given register offset.
    function addr_hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            addr_hit = (addr == off);
        end
    endfunction

    // Read multiplexer; unmapped offsets read as zero so software sees no stale data.
    function [31:0] read_word;
        input [7:0] addr;
        begin
            case (addr)
                `PTS_OFF_COUNT:     read_word = {24'h000000, count_value_q};
                `PTS_OFF_PERIOD:    read_word = {24'h000000, period_value_q};
                `PTS_OFF_CONTROL:   read_word = {24'h000000, timer_control_register_q};
                `PTS_OFF_HLT:       read_word = {25'h0000000, hardware_limit_timer_q};
                `PTS_OFF_RESET_SRC: read_word = {30'h00000000, reset_source_field_q};
                `PTS_OFF_STATUS:    read_word = {30'h00000000, run_q, irq_flag_q};
                `PTS_OFF_IRQ_EN:    read_word = {31'h00000000, match_irq_enable_q};
                default:            read_word = 32'h00000000;
            endcase
        end
    endfunction

    // AHB-Lite register strobes, taken one cycle after the address phase.
    wire ahb_go = hsel & hready & htrans[1];
    wire wr_count   = wr_pend_q & addr_hit(addr_q, `PTS_OFF_COUNT);
    wire wr_period  = wr_pend_q & addr_hit(addr_q, `PTS_OFF_PERIOD);
    wire wr_control = wr_pend_q & addr_hit(addr_q, `PTS_OFF_CONTROL);
    wire wr_hlt     = wr_pend_q & addr_hit(addr_q, `PTS_OFF_HLT);
    wire wr_rsrc    = wr_pend_q & addr_hit(addr_q, `PTS_OFF_RESET_SRC);
    wire wr_irq_en  = wr_pend_q & addr_hit(addr_q, `PTS_OFF_IRQ_EN);
    wire wr_status  = wr_pend_q & addr_hit(addr_q, `PTS_OFF_STATUS);

    // True when the upper mode bits select the given operating family.
    function in_family;
        input [1:0] fam;
        input [1:0] want;
        begin
            in_family = (fam == want);
        end
    endfunction

    // Mode decode: start gate, count enable and hardware reset.
    // Gate modes exist only in the free-running family; the other families turn the same codes into starts.
    reg gate_ok;
    reg hw_reset;
    reg hw_start;
    always @* begin
        gate_ok  = 1'b1;
        hw_reset = 1'b0;
        hw_start = 1'b0;
        case (mode[2:0])
            3'b000: begin
                hw_start = 1'b1;
            end
            3'b001: begin
                if (in_family(mode[4:3], 2'b00)) gate_ok = ers_raw;
                else hw_start = ers_rise;
            end
            3'b010: begin
                if (in_family(mode[4:3], 2'b00)) gate_ok = ~ers_raw;
                else hw_start = ers_fall;
            end
            3'b011: begin
                if (in_family(mode[4:3], 2'b00)) hw_reset = ers_any;
                else hw_start = ers_any;
            end
            3'b100: begin
                hw_reset = ers_rise;
                hw_start = ers_rise;
            end
            3'b101: begin
                hw_reset = ers_fall;
                hw_start = ers_fall;
            end
            3'b110: begin
                hw_reset = ~ers_raw;
                hw_start = ers_rise;
                if (in_family(mode[4:3], 2'b00)) gate_ok = ers_raw;
            end
            default: begin
                hw_reset = ers_raw;
                hw_start = ers_fall;
                if (in_family(mode[4:3], 2'b00)) gate_ok = ~ers_raw;
            end
        endcase
        if (in_family(mode[4:3], 2'b00)) hw_start = 1'b1;
    end

    // Prescaler output tick; with sync it is delayed a register stage to the bus clock.
    wire presc_tick_raw = tclk_rise & presc_wrap(presc_q, ckps);
    wire presc_tick     = prescaler_sync ? presc_out_q : presc_tick_raw;
    wire one_shot_like  = ~in_family(mode[4:3], 2'b00);
    wire running        = run_q & gate_ok & (~one_shot_like | os_armed_q);
    wire at_period      = (count_value_q == period_value_q);
    wire tick           = presc_tick & running;
    wire match_tick     = tick & at_period;
    wire [3:0] post_sel = one_shot_like ? 4'h0 : postscale_select;
    wire post_hit       = match_tick & (post_q == post_sel);
    wire scaler_clr     = wr_count | wr_control | hw_reset;

    // Input sampling: timer clock and external reset edge detectors, and the synchronised prescaler stage.
    // Both detectors reset low, matching the idle level, so no false edge follows reset.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tclk_q      <= 1'b0;
            ers_q       <= 1'b0;
            presc_out_q <= 1'b0;
        end else begin
            tclk_q      <= timer_input_clock;
            ers_q       <= ers_raw;
            presc_out_q <= presc_tick_raw;
        end
    end

    // Run bit: follows ON at once, or waits for a timer clock edge when run-bit sync is set.
    // The edge that starts a synchronised run is not counted unless prescaler sync is on at 1:1; that is the cost of a glitch-free start.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 1'b0;
        end else if (!on_bit) begin
            run_q <= 1'b0;
        end else if (!run_q) begin
            if (!run_bit_sync) run_q <= 1'b1;
            else if (tclk_rise) run_q <= 1'b1;
        end
    end

    // Prescaler and postscaler; count writes, control writes and hardware resets restart both scalers, a period match does not.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_q <= 8'h00;
            post_q  <= 4'h0;
        end else begin
            if (scaler_clr | ~run_q) presc_q <= 8'h00;
            else if (tclk_rise) presc_q <= presc_wrap(presc_q, ckps) ? 8'h00 : presc_q + 8'h01;
            if (scaler_clr) post_q <= 4'h0;
            else if (post_hit) post_q <= 4'h0;
            else if (match_tick) post_q <= post_q + 4'h1;
        end
    end

    // Count and period: software write first, then hardware reset, then period wrap and increment.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_value_q  <= `PTS_COUNT_RST;
            period_value_q <= `PTS_PERIOD_RST;
        end else begin
            if (wr_count) count_value_q <= hwdata[7:0];
            else if (hw_reset) count_value_q <= `PTS_COUNT_RST;
            else if (match_tick) count_value_q <= `PTS_COUNT_RST;
            else if (tick) count_value_q <= count_value_q + 8'h01;
            if (wr_period) period_value_q <= hwdata[7:0];
        end
    end

    // One-shot arming: a start event arms, the period match disarms.
    // The match outranks a fresh start, otherwise a single shot could run on.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            os_armed_q <= 1'b0;
        end else if (!on_bit) begin
            os_armed_q <= 1'b0;
        end else if (match_tick & one_shot_like) begin
            os_armed_q <= 1'b0;
        end else if (hw_start | (hw_reset & in_family(mode[4:3], 2'b10))) begin
            os_armed_q <= 1'b1;
        end
    end

    // Software registers; a one-shot clears ON at its match, but a control write in that cycle wins.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_control_register_q <= 8'h00;
            hardware_limit_timer_q   <= 7'h00;
            reset_source_field_q     <= 2'h0;
            match_irq_enable_q       <= 1'b0;
        end else begin
            if (wr_control) timer_control_register_q <= hwdata[7:0];
            else if (match_tick & in_family(mode[4:3], 2'b01)) timer_control_register_q[`PTS_CTL_ON] <= 1'b0;
            if (wr_hlt) hardware_limit_timer_q <= hwdata[6:0];
            if (wr_rsrc) reset_source_field_q <= hwdata[1:0];
            if (wr_irq_en) match_irq_enable_q <= hwdata[0];
        end
    end

    // Output pulses are registered so every top-level output comes from a flip-flop.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            postscaled_pulse <= 1'b0;
            period_match     <= 1'b0;
        end else begin
            postscaled_pulse <= post_hit;
            period_match     <= match_tick;
        end
    end

    // Two-stage synchroniser for the postscaler hit; only the second stage is read.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_sync1_q <= 1'b0;
            flag_sync2_q <= 1'b0;
        end else begin
            flag_sync1_q <= post_hit;
            flag_sync2_q <= flag_sync1_q;
        end
    end

    // Interrupt flag and request; a set outranks a software clear in the same cycle.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_flag_q <= 1'b0;
            timer_irq  <= 1'b0;
        end else begin
            if (flag_sync2_q) irq_flag_q <= 1'b1;
            else if (wr_status & hwdata[0]) irq_flag_q <= 1'b0;
            timer_irq <= (irq_flag_q | flag_sync2_q) & match_irq_enable_q;
        end
    end

    // AHB-Lite slave: zero wait states, OKAY always, unmapped reads return zero.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_q <= ahb_go & hwrite;
            if (ahb_go) addr_q <= haddr[7:0];
            // Read data is zero outside a read data phase.
            hrdata <= 32'h00000000;
            if (ahb_go & ~hwrite) hrdata <= read_word(haddr[7:0]);
        end
    end
endmodule

// [sim/pts_timer_assertions.sv]
// Port-level checks for the period timer.
`timescale 1ns/1ps
module pts_timer_assertions (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        postscaled_pulse,
    input wire        period_match,
    input wire        timer_irq
);
    logic rd_q;
    logic ew_q;
    logic en_q;
    wire  acc = hsel && hready && htrans[1];
    // Follow read data phases and the enable bit, so masking is judged without peeking inside.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            ew_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            rd_q <= acc && !hwrite;
            ew_q <= acc && hwrite && haddr[7:0] == 8'h18;
            en_q <= ew_q ? hwdata[0] : en_q;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_ready; hreadyout && !hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus not ready or not okay");
    property p_rdata; !rd_q |-> hrdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside a read");
    property p_match; period_match |=> !period_match; endproperty
    a_match: assert property (p_match) else $error("match pulse too long");
    property p_post; postscaled_pulse |=> !postscaled_pulse; endproperty
    a_post: assert property (p_post) else $error("postscaled pulse too long");
    property p_post_src; postscaled_pulse |-> period_match; endproperty
    a_post_src: assert property (p_post_src) else $error("pulse without match");
    property p_irq_set; postscaled_pulse && en_q |-> ##[1:3] timer_irq; endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt late");
    property p_irq_mask; !en_q && !$past(en_q) |-> !timer_irq; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
    property p_quiet; $rose(hresetn) |-> !period_match && !postscaled_pulse && !timer_irq; endproperty
    a_quiet: assert property (p_quiet) else $error("output active after reset");
    c_post: cover property (postscaled_pulse);
    c_irq: cover property ($rose(timer_irq));
    c_rd: cover property (rd_q && hrdata != 32'h0);
endmodule
bind pts_timer pts_timer_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .postscaled_pulse(postscaled_pulse),
    .period_match(period_match), .timer_irq(timer_irq));

// [sim/pts_partner.sv]
// Far-side model: timer input clock and external reset candidates.
`timescale 1ns/1ps
module pts_partner #(
    parameter NSRC = 4
) (
    input  wire             hclk,
    input  wire             run,
    input  wire [1:0]       sel,
    input  wire             ers,
    output logic            tclk,
    output logic [NSRC-1:0] srcs
);
    logic [1:0] ph_q;
    initial begin
        ph_q = 2'h0;
        tclk = 1'b0;
        srcs = '0;
    end
    // Clock of four bus cycles that stands still when stopped; idle candidates toggle so a wrong pick shows.
    always @(posedge hclk) begin
        ph_q <= ph_q + 2'h1;
        tclk <= run ? ph_q[1] : tclk;
        for (int i = 0; i < NSRC; i++) srcs[i] <= (i == sel) ? ers : ph_q[0];
    end
endmodule

// [sim/tb_period_timer_with_scalers.sv]
// Self-checking bench for the period timer.
`timescale 1ns/1ps
module tb_period_timer_with_scalers;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} pts_row_t;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dbg = 1'b0, run = 1'b0, ers = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0]  htrans = 2'h0, sel = 2'h0;
    logic [2:0]  hsize = 3'h2;
    wire  [31:0] hrdata;
    wire  [3:0]  srcs;
    wire         hreadyout, hresp, tclk, post, match, irq;
    int          err_total = 0, compares = 0, cyc = 0, n, i, k;
    pts_row_t    rows[16] = '{'{1'b0,8'h00,32'h0}, '{1'b0,8'h04,32'hFF}, '{1'b0,8'h08,32'h0},
        '{1'b0,8'h0C,32'h0}, '{1'b0,8'h14,32'h0}, '{1'b0,8'h18,32'h0}, '{1'b1,8'h00,32'h5A},
        '{1'b1,8'h08,32'h75}, '{1'b0,8'h00,32'h5A}, '{1'b0,8'h08,32'h75}, '{1'b1,8'h04,32'h33},
        '{1'b0,8'h04,32'h33}, '{1'b1,8'h1C,32'hFF}, '{1'b0,8'h1C,32'h0}, '{1'b1,8'h10,32'h3},
        '{1'b0,8'h10,32'h3}};
    pts_timer #(.NSRC(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .timer_input_clock(tclk), .reset_sources(srcs),
        .debug_mode(dbg), .postscaled_pulse(post), .period_match(match), .timer_irq(irq));
    pts_partner #(.NSRC(4)) u_far (.hclk(hclk), .run(run), .sel(sel), .ers(ers), .tclk(tclk), .srcs(srcs));
    always #10 hclk = ~hclk;
    // The slowest prescaler pass needs about twelve thousand cycles, so this bound only trips on a hang.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_total++;
            stop_test();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One word transfer; the address phase is held until hready is sampled high.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Cycles between two successive pulses of the chosen output.
    task gap(input logic ps);
        n = -1;
        for (int j = 0; j < 9000; j++) begin
            @(posedge hclk);
            #1 if (n >= 0) n++;
            if ((ps ? post : match) === 1'b1) begin
                if (n > 0) break;
                n = 0;
            end
        end
    endtask
    task stop_test();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        foreach (rows[r]) begin
            xfer(rows[r].w, rows[r].a, rows[r].d);
            if (!rows[r].w) check(rd, rows[r].d);
        end
        // Period 3 gives four ticks a match, each tick 4 << ratio cycles long.
        run <= 1'b1;
        xfer(1'b1, 8'h04, 32'h3);
        for (k = 0; k < 8; k++) begin
            xfer(1'b1, 8'h08, 32'h81 | (k << 4));
            gap(1'b0);
            check(n, 32'd16 << k);
            gap(1'b1);
            check(n, 32'd32 << k);
        end
        // Both syncs on; the prescaler output is slower than the bus clock, so the period stays.
        xfer(1'b1, 8'h0C, 32'h60);
        xfer(1'b1, 8'h08, 32'h81);
        gap(1'b0);
        check(n, 32'd16);
        check(irq, 1'b0);
        xfer(1'b0, 8'h14, 32'h0);
        check(rd & 32'h1, 32'h1);
        xfer(1'b1, 8'h08, 32'h0);
        xfer(1'b1, 8'h14, 32'h1);
        xfer(1'b1, 8'h18, 32'h1);
        xfer(1'b1, 8'h0C, 32'h08);
        xfer(1'b1, 8'h00, 32'h0);
        xfer(1'b1, 8'h08, 32'h83);
        // A postscale of four would need 64 cycles; the single shot must fire well before.
        i = 0;
        while (post !== 1'b1 && i < 40) begin
            @(posedge hclk);
            #1 i++;
        end
        check(post, 1'b1);
        repeat (8) @(posedge hclk);
        check(irq, 1'b1);
        xfer(1'b0, 8'h08, 32'h0);
        check(rd, 32'h03);
        xfer(1'b0, 8'h00, 32'h0);
        check(rd, 32'h0);
        xfer(1'b1, 8'h14, 32'h1);
        repeat (2) @(posedge hclk);
        check(irq, 1'b0);
        xfer(1'b1, 8'h0C, 32'h04);
        xfer(1'b1, 8'h10, 32'h2);
        xfer(1'b1, 8'h04, 32'hFF);
        xfer(1'b1, 8'h08, 32'hF0);
        xfer(1'b1, 8'h00, 32'h40);
        sel <= 2'h2;
        dbg <= 1'b1;
        ers <= 1'b1;
        repeat (40) @(posedge hclk);
        xfer(1'b0, 8'h00, 32'h0);
        check(rd & 32'hFE, 32'h40);
        ers <= 1'b0;
        repeat (40) @(posedge hclk);
        dbg <= 1'b0;
        repeat (40) @(posedge hclk);
        ers <= 1'b1;
        repeat (40) @(posedge hclk);
        xfer(1'b0, 8'h00, 32'h0);
        check(rd & 32'hFE, 32'h0);
        // Active-high gate: the count holds while the gate is low and runs once it rises.
        xfer(1'b1, 8'h0C, 32'h01);
        ers <= 1'b0;
        xfer(1'b1, 8'h08, 32'h80);
        xfer(1'b1, 8'h00, 32'h10);
        repeat (40) @(posedge hclk);
        xfer(1'b0, 8'h00, 32'h0);
        check(rd, 32'h10);
        ers <= 1'b1;
        repeat (40) @(posedge hclk);
        xfer(1'b0, 8'h00, 32'h0);
        check(rd >= 32'h18 && rd <= 32'h1F, 1'b1);
        hresetn <= 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, 8'h04, 32'h0);
        check(rd, 32'hFF);
        stop_test();
    end
endmodule
